// ==== pkg/hv_switch_defines.svh ====
// register offsets, field positions, reset values for the high velocity switch
`ifndef HV_SWITCH_DEFINES_SVH
`define HV_SWITCH_DEFINES_SVH
`define HV_OFS_THRESH 8'h00
`define HV_OFS_CTRL 8'h04
`define HV_OFS_STATUS 8'h08
`define HV_OFS_PERIOD 8'h0c
`define HV_THRESH_RST 20'h00000
`define HV_CTRL_RST 4'h0
`define HV_CTRL_NARROW 0
`define HV_CTRL_FULLSTEP 1
`define HV_CTRL_CONSTOFF 2
`define HV_CTRL_PWMEN 3
`define HV_ST_ACTIVE 0
`define HV_ST_FULLSTEP 1
`define HV_ANGLE_45 10'h080
`define HV_RESP_OKAY 2'h0
`define HV_RESP_SLVERR 2'h2
`endif

// ==== pkg/hv_switch_pkg.sv ====
// types shared by the high velocity switch design files
package hv_switch_pkg;
	typedef struct packed
	{
		logic [1:0] chopMode;
		logic [3:0] fastDecayTime;
		logic [4:0] offTime;
		logic [3:0] syncDivider;
	} chop_cfg_s;
	typedef enum logic [1:0]
	{
		AXI_IDLE = 2'b00,
		AXI_RESP = 2'b01
	} bus_state_e;
	typedef enum logic [1:0]
	{
		MODE_MICRO = 2'b00,
		MODE_FULL = 2'b01
	} step_mode_e;
endpackage

// ==== verilog/period_compare.sv ====
// hysteresis comparator for step period versus threshold
module period_compare #(
	parameter int WIDTH = 20
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic [WIDTH-1:0] period,
	input wire logic [WIDTH-1:0] threshold,
	input wire logic narrow,
	output logic inHigh
);
	logic inHigh_ff; // latched high velocity state
	logic nxt_inHigh;
	logic [WIDTH+4:0] scaled; // period scaled by 15/16 or 31/32
	logic [WIDTH+4:0] upper; // scaled minus one
	wire logic enter; // period at or under threshold
	wire logic leave; // upper value above threshold
	assign scaled = narrow ? (({5'h00, period} << 5) - {5'h00, period}) >> 5
		: (({5'h00, period} << 4) - {5'h00, period}) >> 4;
	assign upper = (scaled == '0) ? '0 : scaled - {{(WIDTH+4){1'b0}}, 1'b1};
	assign enter = period <= threshold;
	assign leave = upper > {5'h00, threshold};
	assign nxt_inHigh = enter ? 1'b1 : (leave ? 1'b0 : inHigh_ff);
	// hysteresis state update
	always_ff @(posedge clock)
	begin
		if (reset)
			inHigh_ff <= 1'b0;
		else
			inHigh_ff <= nxt_inHigh;
	end
	assign inHigh = inHigh_ff;
endmodule

// ==== verilog/fullstep_gate.sv ====
// defers entry to and exit from fullstep until the 45 degree position
module fullstep_gate #(
	parameter int AW = 10
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic want,
	input wire logic [AW-1:0] angle,
	input wire logic [AW-1:0] angle45,
	output logic fullOn
);
	hv_switch_pkg::step_mode_e mode_ff; // present step mode
	hv_switch_pkg::step_mode_e nxt_mode;
	wire logic atPoint; // at the 45 degree point
	assign atPoint = angle == angle45;
	assign nxt_mode = !atPoint ? mode_ff
		: (want ? hv_switch_pkg::MODE_FULL : hv_switch_pkg::MODE_MICRO);
	// mode only changes at the 45 degree point
	always_ff @(posedge clock)
	begin
		if (reset)
			mode_ff <= hv_switch_pkg::MODE_MICRO;
		else
			mode_ff <= nxt_mode;
	end
	assign fullOn = mode_ff == hv_switch_pkg::MODE_FULL;
endmodule

// ==== verilog/high_velocity_mode_switch.sv ====
// high velocity mode switch with axi4-lite register access
// Summary of operation
// - threshold register resets zero, sets speed limit
// - high velocity disables load adaptive current scaling
// - high velocity disables voltage pwm mode
// - constant off option forces chm one, decay zero
// - high velocity forces synchronisation divider zero
// - fullstep option drives fullstep, alternate stall detect
// - hysteresis 15/16 or 31/32 minus one
// - fullstep switching only at 45 degree point
// - fullstep current from 45 degree table entry
// - constant off option doubles off time
// - both options may be active together
// - pwm enable flag clear means no pwm mode
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`include "hv_switch_defines.svh"
module high_velocity_mode_switch #(
	parameter int PW = 20,
	parameter int AW = 10,
	parameter int CW = 8
) (
	input wire logic clock,
	input wire logic reset,
	// axi4-lite slave
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// motion side
	input wire logic [PW-1:0] stepPeriod,
	input wire logic [AW-1:0] microAngle,
	input wire logic [CW-1:0] tableCurA,
	input wire logic [CW-1:0] tableCurB,
	input wire logic [CW-1:0] table45Cur,
	input wire logic [CW-1:0] scaledCurrent,
	input wire logic [CW-1:0] normalCurrent,
	input wire logic pwmWanted,
	input wire logic loadStall,
	input wire logic speedStall,
	input wire hv_switch_pkg::chop_cfg_s chopIn,
	// driven to chopper and power stage
	output hv_switch_pkg::chop_cfg_s chopOut,
	output logic [CW-1:0] coilCurA,
	output logic [CW-1:0] coilCurB,
	output logic currentOut,
	output logic pwmModeOn,
	output logic fullstepOn,
	output logic stallFlag,
	output logic [CW-1:0] currentScale
);
	logic [PW-1:0] thresh_ff; // high_speed_threshold
	logic [3:0] ctrl_ff; // option bits
	logic [PW-1:0] nxt_thresh;
	logic [3:0] nxt_ctrl;
	hv_switch_pkg::bus_state_e wst_ff; // write response state
	hv_switch_pkg::bus_state_e rst_ff; // read response state
	logic awHeld_ff; // write address taken
	logic wHeld_ff; // write data taken
	logic [7:0] awAddr_ff;
	logic [31:0] wData_ff;
	logic [3:0] wStrb_ff;
	logic [1:0] bresp_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	hv_switch_pkg::chop_cfg_s chop_ff; // registered chopper setting
	hv_switch_pkg::chop_cfg_s nxt_chop;
	logic [CW-1:0] curA_ff;
	logic [CW-1:0] curB_ff;
	logic [CW-1:0] scale_ff;
	logic pwm_ff;
	logic stall_ff;
	wire logic hvActive; // high velocity operation
	wire logic fullOn; // fullstep engaged at 45 degree point
	wire logic constOff; // constant off option active
	wire logic doWrite; // both write halves present
	wire logic [7:0] rdAddr;
	wire logic [31:0] rdValue;
	wire logic rdOk;
	wire logic wrOk;
	wire logic [4:0] doubledOff;

	// step period comparison with hysteresis
	period_compare #(.WIDTH(PW)) cmp (
		.clock(clock),
		.reset(reset),
		.period(stepPeriod),
		.threshold(thresh_ff),
		.narrow(ctrl_ff[`HV_CTRL_NARROW]),
		.inHigh(hvActive)
	);

	// fullstep engage at 45 degree point
	fullstep_gate #(.AW(AW)) gate (
		.clock(clock),
		.reset(reset),
		.want(hvActive & ctrl_ff[`HV_CTRL_FULLSTEP]),
		.angle(microAngle),
		.angle45(AW'(`HV_ANGLE_45)),
		.fullOn(fullOn)
	);

	// write channel handshakes
	assign awready = !awHeld_ff && wst_ff == hv_switch_pkg::AXI_IDLE;
	assign wready = !wHeld_ff && wst_ff == hv_switch_pkg::AXI_IDLE;
	assign doWrite = awHeld_ff && wHeld_ff && wst_ff == hv_switch_pkg::AXI_IDLE;
	assign bvalid = wst_ff == hv_switch_pkg::AXI_RESP;
	assign bresp = bresp_ff;
	assign wrOk = awAddr_ff == `HV_OFS_THRESH || awAddr_ff == `HV_OFS_CTRL;

	// write merge with byte strobes
	always_comb
	begin
		nxt_thresh = thresh_ff;
		nxt_ctrl = ctrl_ff;
		if (doWrite && awAddr_ff == `HV_OFS_THRESH)
		begin
			if (wStrb_ff[0])
				nxt_thresh[7:0] = wData_ff[7:0];
			if (wStrb_ff[1])
				nxt_thresh[15:8] = wData_ff[15:8];
			if (wStrb_ff[2])
				nxt_thresh[PW-1:16] = wData_ff[PW-1:16];
		end
		if (doWrite && awAddr_ff == `HV_OFS_CTRL && wStrb_ff[0])
			nxt_ctrl = wData_ff[3:0];
	end

	// write path registers
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			awHeld_ff <= 1'b0;
			wHeld_ff <= 1'b0;
			awAddr_ff <= 8'h00;
			wData_ff <= 32'h00000000;
			wStrb_ff <= 4'h0;
			wst_ff <= hv_switch_pkg::AXI_IDLE;
			bresp_ff <= `HV_RESP_OKAY;
			thresh_ff <= `HV_THRESH_RST;
			ctrl_ff <= `HV_CTRL_RST;
		end
		else
		begin
			thresh_ff <= nxt_thresh;
			ctrl_ff <= nxt_ctrl;
			if (awvalid && awready)
			begin
				awHeld_ff <= 1'b1;
				awAddr_ff <= awaddr;
			end
			if (wvalid && wready)
			begin
				wHeld_ff <= 1'b1;
				wData_ff <= wdata;
				wStrb_ff <= wstrb;
			end
			if (doWrite)
			begin
				wst_ff <= hv_switch_pkg::AXI_RESP;
				bresp_ff <= wrOk ? `HV_RESP_OKAY : `HV_RESP_SLVERR;
				awHeld_ff <= 1'b0;
				wHeld_ff <= 1'b0;
			end
			else if (bvalid && bready)
				wst_ff <= hv_switch_pkg::AXI_IDLE;
		end
	end

	// read decode
	assign rdAddr = araddr;
	assign rdOk = rdAddr == `HV_OFS_CTRL || rdAddr == `HV_OFS_STATUS
		|| rdAddr == `HV_OFS_PERIOD || rdAddr == `HV_OFS_THRESH;
	// threshold is write only and reads as zero
	assign rdValue = rdAddr == `HV_OFS_CTRL ? {28'h0000000, ctrl_ff}
		: rdAddr == `HV_OFS_STATUS ? {30'h00000000, fullOn, hvActive}
		: rdAddr == `HV_OFS_PERIOD ? {{(32-PW){1'b0}}, stepPeriod}
		: 32'h00000000;
	assign arready = rst_ff == hv_switch_pkg::AXI_IDLE;
	assign rvalid = rst_ff == hv_switch_pkg::AXI_RESP;
	assign rdata = rdata_ff;
	assign rresp = rresp_ff;

	// read path registers
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			rst_ff <= hv_switch_pkg::AXI_IDLE;
			rdata_ff <= 32'h00000000;
			rresp_ff <= `HV_RESP_OKAY;
		end
		else if (arvalid && arready)
		begin
			rst_ff <= hv_switch_pkg::AXI_RESP;
			rdata_ff <= rdValue;
			rresp_ff <= rdOk ? `HV_RESP_OKAY : `HV_RESP_SLVERR;
		end
		else if (rvalid && rready)
			rst_ff <= hv_switch_pkg::AXI_IDLE;
	end

	// chopper override
	assign constOff = hvActive && ctrl_ff[`HV_CTRL_CONSTOFF];
	// doubled off time saturates at field maximum
	assign doubledOff = chopIn.offTime[4] ? 5'h1f : {chopIn.offTime[3:0], 1'b0};
	always_comb
	begin
		nxt_chop = chopIn;
		if (hvActive)
			nxt_chop.syncDivider = 4'h0;
		if (constOff)
		begin
			nxt_chop.chopMode = 2'h1;
			nxt_chop.fastDecayTime = 4'h0;
			nxt_chop.offTime = doubledOff;
		end
	end

	// registered outputs to power stage
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			chop_ff <= '0;
			curA_ff <= '0;
			curB_ff <= '0;
			scale_ff <= '0;
			pwm_ff <= 1'b0;
			stall_ff <= 1'b0;
		end
		else
		begin
			chop_ff <= nxt_chop;
			curA_ff <= fullOn ? table45Cur : tableCurA;
			curB_ff <= fullOn ? table45Cur : tableCurB;
			scale_ff <= hvActive ? normalCurrent : scaledCurrent;
			pwm_ff <= ctrl_ff[`HV_CTRL_PWMEN] && pwmWanted && !hvActive;
			stall_ff <= fullOn ? speedStall : loadStall;
		end
	end
	assign chopOut = chop_ff;
	assign coilCurA = curA_ff;
	assign coilCurB = curB_ff;
	assign currentScale = scale_ff;
	assign currentOut = hvActive;
	assign pwmModeOn = pwm_ff;
	assign fullstepOn = fullOn;
	assign stallFlag = stall_ff;

	// pwm mode never on in high velocity or when disabled
	AST_PWM_OFF: assert property (@(posedge clock) disable iff (reset)
		hvActive |=> !pwmModeOn)
		else $error("pwm mode on during high velocity");
	AST_PWM_FLAG: assert property (@(posedge clock) disable iff (reset)
		!ctrl_ff[`HV_CTRL_PWMEN] |=> !pwmModeOn)
		else $error("pwm mode on with flag clear");
	AST_SYNC_ZERO: assert property (@(posedge clock) disable iff (reset)
		hvActive |=> chopOut.syncDivider == 4'h0)
		else $error("sync divider not zero");
	AST_CONSTOFF: assert property (@(posedge clock) disable iff (reset)
		constOff |=> chopOut.chopMode == 2'h1 && chopOut.fastDecayTime == 4'h0)
		else $error("chopper not forced to constant off");
	AST_TOFF_DOUBLE: assert property (@(posedge clock) disable iff (reset)
		(constOff && !chopIn.offTime[4]) |=> chopOut.offTime == {$past(chopIn.offTime[3:0]), 1'b0})
		else $error("off time not doubled");
	AST_SCALE: assert property (@(posedge clock) disable iff (reset)
		hvActive |=> currentScale == $past(normalCurrent))
		else $error("current scaling active at high velocity");
	AST_ENTER: assert property (@(posedge clock) disable iff (reset)
		stepPeriod <= thresh_ff |=> hvActive)
		else $error("high velocity not entered");
	AST_FULL_45: assert property (@(posedge clock) disable iff (reset)
		$changed(fullOn) |-> $past(microAngle) == AW'(`HV_ANGLE_45))
		else $error("fullstep changed off the 45 degree point");
	AST_CUR45: assert property (@(posedge clock) disable iff (reset)
		fullOn |=> coilCurA == $past(table45Cur))
		else $error("fullstep current not from 45 degree entry");
	AST_STALL: assert property (@(posedge clock) disable iff (reset)
		fullOn |=> stallFlag == $past(speedStall))
		else $error("stall source not switched");
	AST_THRESH_RST: assert property (@(posedge clock)
		reset |=> thresh_ff == `HV_THRESH_RST)
		else $error("threshold not reset to zero");
	AST_BOTH: assert property (@(posedge clock) disable iff (reset)
		(fullOn && constOff && ctrl_ff[`HV_CTRL_FULLSTEP]) |=> chopOut.chopMode == 2'h1 && fullstepOn)
		else $error("options not combined");
endmodule

// ==== verification/motor_stage_model.sv ====
// behavioural motor stage: microstep angle source, table currents, stall lines
module motor_stage_model
(
	input wire logic clock,
	input wire logic reset,
	input wire logic run,
	output logic [9:0] microAngle,
	output logic [7:0] tableCurA,
	output logic [7:0] tableCurB,
	output logic [7:0] table45Cur,
	output logic loadStall,
	output logic speedStall
);
	timeunit 1ns;
	timeprecision 1ns;
	// distinct table entries so that a wrong selection shows
	assign tableCurA = 8'h31;
	assign tableCurB = 8'h52;
	assign table45Cur = 8'hb5;
	// opposite stall levels expose a wrong detector choice
	assign loadStall = 1'b1;
	assign speedStall = 1'b0;
	// angle advances one microstep a cycle while the motor runs
	always_ff @(posedge clock)
	begin
		if (reset)
			microAngle <= 10'h000;
		else if (run)
			microAngle <= microAngle + 10'h001;
	end
endmodule

// ==== verification/high_velocity_mode_switch_tb_top.sv ====
// self-checking bench for the high velocity mode switch
`include "hv_switch_defines.svh"
module high_velocity_mode_switch_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock, reset, awvalid, wvalid, bready, arvalid, rready, pwmWanted, run;
	logic awready, wready, bvalid, arready, rvalid, currentOut, pwmModeOn;
	logic fullstepOn, stallFlag, loadStall, speedStall;
	logic [7:0] awaddr, araddr, scaledCurrent, normalCurrent, tableCurA, tableCurB;
	logic [7:0] table45Cur, coilCurA, coilCurB, currentScale;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb, ctl;
	logic [1:0] bresp, rresp;
	logic [19:0] stepPeriod;
	logic [9:0] microAngle;
	hv_switch_pkg::chop_cfg_s chopIn, chopOut;
	int errTotal, totalChecks;
	high_velocity_mode_switch i_dut (.clock, .reset, .awaddr, .awvalid, .awready, .wdata,
		.wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
		.rdata, .rresp, .rvalid, .rready, .stepPeriod, .microAngle, .tableCurA, .tableCurB,
		.table45Cur, .scaledCurrent, .normalCurrent, .pwmWanted, .loadStall, .speedStall,
		.chopIn, .chopOut, .coilCurA, .coilCurB, .currentOut, .pwmModeOn, .fullstepOn,
		.stallFlag, .currentScale);
	motor_stage_model i_stage (.clock, .reset, .run, .microAngle, .tableCurA, .tableCurB,
		.table45Cur, .loadStall, .speedStall);
	// free running clock, 100 ns period
	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// compare and count
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		totalChecks++;
		if (s !== e)
		begin
			$display("MISMATCH %s expected %h seen %h", n, e, s);
			errTotal++;
		end
	endtask
	// axi4-lite write, halves released as each is taken
	task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clock);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end
		while ((awvalid && !awready) || (wvalid && !wready));
		do @(posedge clock); while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask
	// axi4-lite read
	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clock); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clock); while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	// upper speed bound of the hysteresis band
	function automatic int up(input int p);
		return ctl[0] ? p * 31 / 32 - 1 : p * 15 / 16 - 1;
	endfunction
	// expected chopper override
	function automatic hv_switch_pkg::chop_cfg_s expChop(input logic hv);
		hv_switch_pkg::chop_cfg_s c;
		c = chopIn;
		if (hv)
		begin
			c.syncDivider = 4'h0;
			if (ctl[2])
			begin
				c.chopMode = 2'h1;
				c.fastDecayTime = 4'h0;
				c.offTime = (c.offTime > 5'h0f) ? 5'h1f : {c.offTime[3:0], 1'b0};
			end
		end
		return c;
	endfunction
	// all motion side outputs against one operating state
	task ochk(input logic hv, input logic fs);
		chk("speed", currentOut, hv);
		chk("chop", chopOut, expChop(hv));
		chk("scale", currentScale, hv ? normalCurrent : scaledCurrent);
		chk("pwm", pwmModeOn, ctl[3] & pwmWanted & !hv);
		chk("full", fullstepOn, fs);
		chk("coil", coilCurA, fs ? table45Cur : tableCurA);
		chk("coilB", coilCurB, fs ? table45Cur : tableCurB);
		chk("stall", stallFlag, fs ? speedStall : loadStall);
	endtask
	// verdict
	task end_of_test();
		$display("checks %0d mismatches %0d", totalChecks, errTotal);
		if (errTotal == 0 && totalChecks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// watchdog against a hung handshake
	initial
	begin
		#6000000;
		errTotal++;
		end_of_test();
	end
	// main sequence
	initial
	begin
		logic [31:0] d;
		logic [1:0] r;
		int thr;
		int px;
		void'($urandom(32'hd7d2e8a8));
		{reset, run, awvalid, wvalid, bready, arvalid, rready, pwmWanted} = 8'h80;
		{awaddr, araddr, wdata, wstrb, ctl} = '0;
		{scaledCurrent, normalCurrent, chopIn} = '0;
		stepPeriod = 20'hfffff;
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		rd(`HV_OFS_THRESH, d, r);
		chk("thresh", d, 32'h0);
		rd(`HV_OFS_CTRL, d, r);
		chk("ctrl", d, 32'h0);
		wr(8'h10, 32'hffffffff, r);
		chk("bresp", r, `HV_RESP_SLVERR);
		rd(8'h10, d, r);
		chk("rresp", r, `HV_RESP_SLVERR);
		for (int i = 0; i < 8; i++)
		begin
			thr = 64 + $urandom % 400000;
			// first pass sets every option bit, second clears them all
			ctl = (i == 0) ? 4'hf : ((i == 1) ? 4'h0 : 4'($urandom));
			chopIn <= 15'($urandom);
			pwmWanted <= (i == 0) ? 1'b1 : 1'($urandom);
			scaledCurrent <= 8'($urandom);
			normalCurrent <= 8'($urandom);
			wr(`HV_OFS_THRESH, 32'(thr), r);
			wr(`HV_OFS_CTRL, 32'(ctl), r);
			chk("bresp", r, `HV_RESP_OKAY);
			stepPeriod <= 20'(2 * thr + 64);
			run <= 1'b1;
			repeat (1100) @(posedge clock);
			ochk(1'b0, 1'b0);
			// enter at the exact threshold with the motor parked off 45 degrees
			run <= 1'b0;
			stepPeriod <= 20'(thr);
			repeat (4) @(posedge clock);
			if (microAngle !== `HV_ANGLE_45) ochk(1'b1, 1'b0);
			// last period inside the band keeps high velocity
			px = thr + 1;
			while (up(px) <= thr) px++;
			stepPeriod <= 20'(px - 1);
			run <= 1'b1;
			repeat (1100) @(posedge clock);
			ochk(1'b1, ctl[1]);
			rd(`HV_OFS_STATUS, d, r);
			chk("status", d, {30'h0, ctl[1], 1'b1});
			rd(`HV_OFS_PERIOD, d, r);
			chk("period", d, 32'(px - 1));
			// first period past the band leaves, fullstep held until 45 degrees
			run <= 1'b0;
			stepPeriod <= 20'(px);
			repeat (4) @(posedge clock);
			if (microAngle !== `HV_ANGLE_45) ochk(1'b0, ctl[1]);
		end
		end_of_test();
	end
endmodule
